/* File: dsp_device.sv */
// Debug status outputs, scan test controller and serial debug port of the processor.
// Assumes the pin side is joined through dsp_if and the core side runs on core_clk_in.
// Operation
// [RULE1] Four-bit debug data bus shows captured data.
// [RULE2] Status nibble follows status clock, core state.
// [RULE3] Codes 0000-0111 for execution events, two reserved.
// [RULE4] Codes 1000-1011 announce 1-4 byte transfers.
// [RULE5] Codes 1100-1111 held for several cycles.
// [RULE6] Scan logic keeps state with stopped test clock.
// [RULE7] Shared pin is serial clock or test reset.
// [RULE8] Debugger keeps test mode stable outside reset.
// [RULE9] Test reset forces idle reset state, bypass.
// [RULE10] Release test reset only with mode select high.
// [RULE11] Undriven test reset reads high via pull-up.
// [RULE12] Five clocks with mode select high reset.
// [RULE13] Serial clock at most one fifth bus clock.
// [RULE14] Shared pin is breakpoint or mode select.
// [RULE15] Sixteen-state controller steps on rising test clock.
// [RULE16] Breakpoint input signals core breakpoint in debug.
// [RULE17] Test data shifts into selected register rising.
// [RULE18] Serial debug commands in, responses out bitwise.
// [RULE19] Test data out changes falling, otherwise floats.
// [RULE20] Serial pins carry debug or scan data.
// [RULE21] Reset input starts exception, floats data bus.
// [RULE22] Status clock at twice the bus clock.
// [RULE23] Lowest mode bit picks debug or scan; code decodes all four mode bits, 0000 scan, 0001 debug, others neither.
// [RULE24] Test data out driven only in shift states.
module dsp_device
  import dsp_pkg::*;
(
  input  wire logic              core_clk_in,
  input  wire logic              rst_n_in,
  dsp_if.dev                     pins,
  input  wire logic [3:0]        core_status_in,
  input  wire logic              core_xfer_req_in,
  input  wire logic [1:0]        core_xfer_bytes_in,
  input  wire logic [31:0]       core_xfer_data_in,
  input  wire logic [DBUS_W-1:0] core_bus_data_in,
  input  wire logic              core_bus_drive_in,
  output logic                   core_xfer_ack_out,
  output logic                   core_xfer_busy_out,
  output logic                   core_breakpoint_out,
  output logic                   core_reset_exc_out
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [8:0] pin_raw;
  logic [8:0] meta_q;
  logic [8:0] sync_q;
  assign pin_raw = {pins.reset_input_n, pins.tck, pins.trst_debug_serial_clock, pins.tms_breakpoint_input,
                    pins.tdi_dsi, pins.test_mode};

  for (genvar i = 0; i < 9; i++) begin : g_sync
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
        meta_q[i] <= SYNC_RST[i]; // [RULE11]
        sync_q[i] <= SYNC_RST[i];
      end else begin
        meta_q[i] <= pin_raw[i];
        sync_q[i] <= meta_q[i];
      end
    end
  end

  logic       rst_pin_n;
  logic       tck_s;
  logic       trst_s;
  logic       tms_s;
  logic       tdi_s;
  logic [3:0] mode_s;
  assign {rst_pin_n, tck_s, trst_s, tms_s, tdi_s, mode_s} = sync_q;

  logic mode_scan;
  logic mode_bdm;
  assign mode_scan = (mode_s == MODE_SCAN); // [RULE20]
  assign mode_bdm  = (mode_s == MODE_BDM);

  logic tck_q;
  logic trst_q;
  logic tms_q;
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tck_q  <= 1'b0;
      trst_q <= 1'b1;
      tms_q  <= 1'b1;
    end else begin
      tck_q  <= tck_s;
      trst_q <= trst_s;
      tms_q  <= tms_s;
    end
  end

  logic tck_rise;
  logic tck_fall;
  logic trst_act;
  logic debug_serial_clock_rise;
  assign tck_rise   = mode_scan && tck_s && !tck_q; // [RULE6]
  assign tck_fall   = mode_scan && !tck_s && tck_q;
  assign trst_act   = mode_scan && !trst_s; // [RULE7]
  assign debug_serial_clock_rise = mode_bdm && trst_s && !trst_q; // [RULE7]

  // ****************************************
  // Scan test controller
  // ****************************************
  dsp_tap_t        tap_q;
  logic [IR_W-1:0] ir_q;
  logic [IR_W-1:0] ir_sr_q;
  logic [DR_W-1:0] dr_sr_q;
  logic [BSR_W-1:0] bsr_q;
  logic [DR_W-1:0] dr_shift;
  logic [4:0]      dr_msb;

  always_comb begin
    case (ir_q)
      IR_IDCODE: dr_msb = 5'd31;
      IR_EXTEST: dr_msb = 5'(BSR_W - 1);
      IR_SAMPLE: dr_msb = 5'(BSR_W - 1);
      default:   dr_msb = 5'd0;
    endcase
    dr_shift         = dr_sr_q >> 1;
    dr_shift[dr_msb] = tdi_s; // [RULE17]
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tap_q <= T_TLR;
    end else if (trst_act) begin
      tap_q <= T_TLR; // [RULE9]
    end else if (tck_rise) begin
      tap_q <= dsp_tap_next(tap_q, tms_s); // [RULE15] [RULE12]
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ir_q    <= IR_BYPASS;
      ir_sr_q <= IR_BYPASS;
      dr_sr_q <= '0;
      bsr_q   <= '0;
    end else if (trst_act || (tck_rise && tap_q == T_TLR)) begin
      ir_q <= IR_BYPASS; // [RULE9]
    end else if (tck_rise) begin
      case (tap_q)
        T_CIR:   ir_sr_q <= IR_CAPTURE;
        T_SHI:   ir_sr_q <= {tdi_s, ir_sr_q[IR_W-1:1]}; // [RULE17]
        T_UIR:   ir_q    <= ir_sr_q;
        T_CDR: begin
          if (ir_q == IR_IDCODE) begin
            dr_sr_q <= ID_VALUE;
          end else if (ir_q == IR_SAMPLE || ir_q == IR_EXTEST) begin
            dr_sr_q <= {{(DR_W-BSR_W){1'b0}}, pins.processor_status_nibble, pins.debug_data_nibble};
          end else begin
            dr_sr_q <= '0;
          end
        end
        T_SHD:   dr_sr_q <= dr_shift;
        T_UDR: begin
          if (ir_q == IR_EXTEST || ir_q == IR_SAMPLE) begin
            bsr_q <= dr_sr_q[BSR_W-1:0];
          end
        end
        default: ir_q <= ir_q;
      endcase
    end
  end

  // ****************************************
  // Serial debug port
  // ****************************************
  logic [BDM_W-1:0] bdm_in_q;
  logic [BDM_W-1:0] bdm_out_q;
  logic [2:0]       bdm_cnt_q;
  logic             bdm_break_q;
  logic [BDM_W-1:0] bdm_cmd;
  assign bdm_cmd = {bdm_in_q[BDM_W-2:0], tdi_s};

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      bdm_in_q    <= '0;
      bdm_out_q   <= '0;
      bdm_cnt_q   <= '0;
      bdm_break_q <= 1'b0;
    end else begin
      bdm_break_q <= 1'b0;
      if (!mode_bdm) begin
        bdm_cnt_q <= '0;
      end else if (debug_serial_clock_rise) begin
        bdm_in_q  <= bdm_cmd; // [RULE18]
        bdm_cnt_q <= bdm_cnt_q + 3'd1;
        bdm_out_q <= {bdm_out_q[BDM_W-2:0], 1'b0};
        if (bdm_cnt_q == 3'd7) begin
          if (bdm_cmd == CMD_STATUS) begin
            bdm_out_q <= {pins.processor_status_nibble, pins.debug_data_nibble};
          end else if (bdm_cmd == CMD_BREAK) begin
            bdm_out_q   <= BDM_ACK;
            bdm_break_q <= 1'b1;
          end else begin
            bdm_out_q <= BDM_NAK;
          end
        end
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      core_breakpoint_out <= 1'b0;
    end else begin
      core_breakpoint_out <= (mode_bdm && !tms_s && tms_q) || bdm_break_q; // [RULE14] [RULE16]
    end
  end

  // ****************************************
  // Shared serial output pin
  // ****************************************
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pins.tdo_dso_o    <= 1'b1;
      pins.tdo_dso_oe_n <= 1'b1;
    end else if (mode_bdm) begin
      pins.tdo_dso_o    <= bdm_out_q[BDM_W-1]; // [RULE18] [RULE20]
      pins.tdo_dso_oe_n <= 1'b0;
    end else if (!mode_scan || trst_act) begin
      pins.tdo_dso_oe_n <= 1'b1;
    end else if (tck_fall) begin
      pins.tdo_dso_o    <= (tap_q == T_SHI) ? ir_sr_q[0] : dr_sr_q[0]; // [RULE19]
      pins.tdo_dso_oe_n <= !(tap_q == T_SHI || tap_q == T_SHD); // [RULE24]
    end
  end

  // ****************************************
  // Status clocks and status nibble
  // ****************************************
  logic       st_en;
  logic [3:0] nib_left_q;
  logic [1:0] hold_q;
  logic [31:0] xfer_q;
  logic [3:0] core_code;
  assign st_en = pins.status_clock_output;
  assign core_code = (core_status_in == PS_RSV2 || core_status_in == PS_RSV6) ? PS_CONT : core_status_in; // [RULE3]

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pins.status_clock_output <= 1'b0;
      pins.bus_clock_output    <= 1'b0;
    end else begin
      pins.status_clock_output <= !pins.status_clock_output; // [RULE22]
      if (pins.status_clock_output) begin
        pins.bus_clock_output <= !pins.bus_clock_output;
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pins.processor_status_nibble <= PS_CONT;
      pins.debug_data_nibble       <= 4'h0;
      nib_left_q         <= '0;
      hold_q             <= '0;
      xfer_q             <= '0;
      core_xfer_ack_out  <= 1'b0;
      core_xfer_busy_out <= 1'b0;
      core_reset_exc_out <= 1'b0;
    end else begin
      core_xfer_ack_out  <= 1'b0;
      core_reset_exc_out <= !rst_pin_n; // [RULE21]
      if (st_en) begin // [RULE2]
        if (nib_left_q != 4'h0) begin
          pins.debug_data_nibble <= xfer_q[3:0]; // [RULE1]
          xfer_q     <= xfer_q >> 4;
          nib_left_q <= nib_left_q - 4'h1;
          core_xfer_busy_out <= (nib_left_q != 4'h1);
        end
        if (mode_scan && ir_q == IR_EXTEST) begin
          pins.processor_status_nibble <= bsr_q[7:4];
          pins.debug_data_nibble       <= bsr_q[3:0];
        end else if (!rst_pin_n) begin
          pins.processor_status_nibble <= PS_EXC;
          hold_q <= HOLD_MIN;
        end else if (hold_q != 2'h0) begin
          hold_q <= hold_q - 2'h1; // [RULE5]
        end else if (core_xfer_req_in && !core_xfer_busy_out) begin
          pins.processor_status_nibble <= PS_XFER1 + {2'h0, core_xfer_bytes_in}; // [RULE4]
          xfer_q             <= core_xfer_data_in;
          nib_left_q         <= {1'b0, core_xfer_bytes_in, 1'b0} + 4'h2;
          core_xfer_busy_out <= 1'b1;
          core_xfer_ack_out  <= 1'b1;
        end else begin
          pins.processor_status_nibble <= core_code; // [RULE3]
          if (core_code[3:2] == 2'b11) begin
            hold_q <= HOLD_MIN - 2'h1; // [RULE5]
          end
        end
      end
    end
  end

  // ****************************************
  // Data bus
  // ****************************************
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pins.data_bus_o    <= '0;
      pins.data_bus_oe_n <= 1'b1;
    end else begin
      pins.data_bus_o    <= core_bus_data_in;
      pins.data_bus_oe_n <= !(core_bus_drive_in && rst_pin_n); // [RULE21]
    end
  end

endmodule : dsp_device

/* File: dsp_pkg.sv */
// Constants, types and the scan controller step function shared by both ends.
// Assumes a single 100 MHz core clock on each end.
package dsp_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CORE_PERIOD_NS = 10;
  localparam int TCK_PERIOD_NS  = 160;
  localparam int TCK_HALF       = TCK_PERIOD_NS / CORE_PERIOD_NS / 2;
  localparam int BUS_PERIOD_NS  = 4 * CORE_PERIOD_NS;
  localparam int DEBUG_SERIAL_CLOCK_PERIOD_NS = 5 * BUS_PERIOD_NS;
  localparam int DEBUG_SERIAL_CLOCK_HALF     = (DEBUG_SERIAL_CLOCK_PERIOD_NS + 2 * CORE_PERIOD_NS - 1) / (2 * CORE_PERIOD_NS);
  localparam int TRST_HOLD      = 4;
  localparam int RESET_TMS_CLKS = 5;
  localparam logic [1:0] HOLD_MIN = 2'h2;

  // ****************************************
  // Test modes and status codes
  // ****************************************
  localparam logic [3:0] MODE_SCAN = 4'h0;
  localparam logic [3:0] MODE_BDM  = 4'h1;
  localparam logic [3:0] PS_CONT   = 4'h0;
  localparam logic [3:0] PS_BEGIN  = 4'h1;
  localparam logic [3:0] PS_RSV2   = 4'h2;
  localparam logic [3:0] PS_USER   = 4'h3;
  localparam logic [3:0] PS_PULSE  = 4'h4;
  localparam logic [3:0] PS_BRANCH = 4'h5;
  localparam logic [3:0] PS_RSV6   = 4'h6;
  localparam logic [3:0] PS_RTE    = 4'h7;
  localparam logic [3:0] PS_XFER1  = 4'h8;
  localparam logic [3:0] PS_EXC    = 4'hC;
  localparam logic [3:0] PS_EMU    = 4'hD;
  localparam logic [3:0] PS_STOP   = 4'hE;
  localparam logic [3:0] PS_HALT   = 4'hF;

  // ****************************************
  // Scan and serial debug layout
  // ****************************************
  localparam int IR_W   = 4;
  localparam int DR_W   = 32;
  localparam int BSR_W  = 8;
  localparam int DBUS_W = 16;
  localparam int BDM_W  = 8;
  localparam logic [IR_W-1:0] IR_EXTEST  = 4'h0;
  localparam logic [IR_W-1:0] IR_IDCODE  = 4'h1;
  localparam logic [IR_W-1:0] IR_SAMPLE  = 4'h2;
  localparam logic [IR_W-1:0] IR_BYPASS  = 4'hF;
  localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;
  // Identification value is arbitrary.
  localparam logic [DR_W-1:0] ID_VALUE   = 32'h0000_0A01;
  localparam logic [BDM_W-1:0] CMD_STATUS = 8'h01;
  localparam logic [BDM_W-1:0] CMD_BREAK  = 8'h02;
  localparam logic [BDM_W-1:0] BDM_ACK    = 8'hA5;
  localparam logic [BDM_W-1:0] BDM_NAK    = 8'hFF;
  localparam logic [8:0] SYNC_RST = 9'h070;

  localparam logic [1:0] OP_TAP_RESET = 2'h0;
  localparam logic [1:0] OP_IR        = 2'h1;
  localparam logic [1:0] OP_DR        = 2'h2;
  localparam logic [1:0] OP_BDM       = 2'h3;

  typedef enum logic [3:0] {
    T_TLR, T_RTI, T_SDR, T_CDR, T_SHD, T_E1D, T_PDR, T_E2D,
    T_UDR, T_SIR, T_CIR, T_SHI, T_E1I, T_PIR, T_E2I, T_UIR
  } dsp_tap_t;

  function automatic dsp_tap_t dsp_tap_next(input dsp_tap_t s, input logic tms);
    dsp_tap_t n;
    n = T_TLR;
    case (s)
      T_TLR:   n = tms ? T_TLR : T_RTI;
      T_RTI:   n = tms ? T_SDR : T_RTI;
      T_SDR:   n = tms ? T_SIR : T_CDR;
      T_CDR:   n = tms ? T_E1D : T_SHD;
      T_SHD:   n = tms ? T_E1D : T_SHD;
      T_E1D:   n = tms ? T_UDR : T_PDR;
      T_PDR:   n = tms ? T_E2D : T_PDR;
      T_E2D:   n = tms ? T_UDR : T_SHD;
      T_UDR:   n = tms ? T_SDR : T_RTI;
      T_SIR:   n = tms ? T_TLR : T_CIR;
      T_CIR:   n = tms ? T_E1I : T_SHI;
      T_SHI:   n = tms ? T_E1I : T_SHI;
      T_E1I:   n = tms ? T_UIR : T_PIR;
      T_PIR:   n = tms ? T_E2I : T_PIR;
      T_E2I:   n = tms ? T_UIR : T_SHI;
      T_UIR:   n = tms ? T_SDR : T_RTI;
      default: n = T_TLR;
    endcase
    return n;
  endfunction : dsp_tap_next

endpackage : dsp_pkg

/* File: dsp_if.sv */
// Pins between the debug port device and the external debugger.
// Assumes the bench joins both ends; the interface resolves pulled-up lines.
interface dsp_if;
  import dsp_pkg::*;

  logic [3:0]        test_mode;
  logic              reset_input_n;
  logic              tck;
  logic              trst_o;
  logic              trst_oe_n;
  logic              tms_o;
  logic              tms_oe_n;
  logic              tdi_o;
  logic              tdi_oe_n;
  logic              trst_debug_serial_clock;
  logic              tms_breakpoint_input;
  logic              tdi_dsi;
  logic              tdo_dso_o;
  logic              tdo_dso_oe_n;
  logic              status_clock_output;
  logic              bus_clock_output;
  logic [3:0]        processor_status_nibble;
  logic [3:0]        debug_data_nibble;
  logic [DBUS_W-1:0] data_bus_o;
  logic              data_bus_oe_n;

  // ****************************************
  // Pulled-up shared inputs
  // ****************************************
  assign trst_debug_serial_clock = trst_oe_n ? 1'b1 : trst_o; // [RULE11]
  assign tms_breakpoint_input   = tms_oe_n ? 1'b1 : tms_o;
  assign tdi_dsi    = tdi_oe_n ? 1'b1 : tdi_o;

  modport dev (
    input  test_mode, reset_input_n, tck, trst_debug_serial_clock, tms_breakpoint_input, tdi_dsi,
    output tdo_dso_o, tdo_dso_oe_n, status_clock_output, bus_clock_output,
    output processor_status_nibble, debug_data_nibble, data_bus_o, data_bus_oe_n
  );

  modport host (
    output test_mode, reset_input_n, tck, trst_o, trst_oe_n, tms_o, tms_oe_n,
    output tdi_o, tdi_oe_n,
    input  tdo_dso_o, tdo_dso_oe_n, status_clock_output, bus_clock_output,
    input  processor_status_nibble, debug_data_nibble, data_bus_o, data_bus_oe_n
  );
endinterface : dsp_if

/* File: dsp_host.sv */
// External debugger end: drives test mode, scan clock and serial debug clock.
// Assumes the pin side is joined through dsp_if and the user side runs on core_clk_in.
module dsp_host
  import dsp_pkg::*;
(
  input  wire logic        core_clk_in,
  input  wire logic        rst_n_in,
  dsp_if.host              pins,
  input  wire logic [3:0]  mode_in,
  input  wire logic        cpu_reset_n_in,
  input  wire logic        op_start_in,
  input  wire logic [1:0]  op_kind_in,
  input  wire logic [5:0]  op_len_in,
  input  wire logic [31:0] op_data_in,
  output logic             op_busy_out,
  output logic             op_done_out,
  output logic [31:0]      op_data_out
);

  typedef enum logic [1:0] {H_IDLE, H_TRST, H_RUN} dsp_hstate_t;

  dsp_hstate_t state_q;
  logic [1:0]  kind_q;
  logic [5:0]  len_q;
  logic [31:0] tx_q;
  logic [6:0]  step_q;
  logic [6:0]  total_q;
  logic [4:0]  ph_q;
  logic [4:0]  half;
  logic        in_meta_q;
  logic        in_sync_q;
  logic        tms_v;
  logic        tdi_v;
  logic [6:0]  pre;
  logic [6:0]  sidx;

  assign half = (kind_q == OP_BDM) ? 5'(DEBUG_SERIAL_CLOCK_HALF) : 5'(TCK_HALF); // [RULE13]
  assign pre  = (kind_q == OP_IR) ? 7'd4 : 7'd3;
  assign sidx = step_q - pre;

  // ****************************************
  // Bit pattern of the current step
  // ****************************************
  always_comb begin
    tms_v = 1'b0;
    tdi_v = 1'b1;
    case (kind_q)
      OP_TAP_RESET: tms_v = (step_q < 7'(RESET_TMS_CLKS)); // [RULE12]
      OP_BDM:       tdi_v = tx_q[7 - step_q[2:0]]; // [RULE18]
      default: begin
        if (step_q < pre) begin
          tms_v = (step_q == 7'd0) || (kind_q == OP_IR && step_q == 7'd1);
        end else if (sidx < {1'b0, len_q}) begin
          tms_v = (sidx == {1'b0, len_q} - 7'd1);
          tdi_v = tx_q[sidx[4:0]];
        end else begin
          tms_v = (sidx == {1'b0, len_q});
        end
      end
    endcase
  end

  // ****************************************
  // Response input synchroniser
  // ****************************************
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      in_meta_q <= 1'b1;
      in_sync_q <= 1'b1;
    end else begin
      in_meta_q <= pins.tdo_dso_oe_n ? 1'b1 : pins.tdo_dso_o;
      in_sync_q <= in_meta_q;
    end
  end

  // ****************************************
  // Sequencer
  // ****************************************
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_q     <= H_IDLE;
      kind_q      <= OP_TAP_RESET;
      len_q       <= '0;
      tx_q        <= '0;
      step_q      <= '0;
      total_q     <= '0;
      ph_q        <= '0;
      op_busy_out <= 1'b0;
      op_done_out <= 1'b0;
      op_data_out <= '0;
      pins.tck    <= 1'b0;
      pins.trst_o <= 1'b1;
      pins.tms_o  <= 1'b1;
      pins.tdi_o  <= 1'b1;
    end else begin
      op_done_out <= 1'b0;
      case (state_q)
        H_IDLE: begin
          pins.trst_o <= 1'b1;
          if (op_start_in) begin
            kind_q      <= op_kind_in;
            len_q       <= op_len_in;
            tx_q        <= op_data_in;
            step_q      <= '0;
            ph_q        <= '0;
            op_busy_out <= 1'b1;
            op_data_out <= '0;
            case (op_kind_in)
              OP_TAP_RESET: total_q <= 7'(RESET_TMS_CLKS + 1);
              OP_BDM:       total_q <= 7'(BDM_W);
              OP_IR:        total_q <= {1'b0, op_len_in} + 7'd6;
              default:      total_q <= {1'b0, op_len_in} + 7'd5;
            endcase
            if (op_kind_in == OP_TAP_RESET && mode_in == MODE_SCAN) begin
              state_q     <= H_TRST;
              pins.trst_o <= 1'b0;
              pins.tms_o  <= 1'b1;
            end else begin
              state_q <= H_RUN;
            end
          end
        end
        H_TRST: begin
          ph_q <= ph_q + 5'd1;
          if (ph_q == 5'(TRST_HOLD - 1)) begin
            pins.trst_o <= 1'b1; // [RULE10]
            ph_q        <= '0;
            state_q     <= H_RUN;
          end
        end
        H_RUN: begin
          ph_q <= ph_q + 5'd1;
          if (ph_q == 5'd0) begin
            pins.tms_o <= tms_v;
            pins.tdi_o <= tdi_v;
            if (kind_q == OP_BDM) begin
              pins.trst_o <= 1'b0; // [RULE18]
            end
          end else if (ph_q == half) begin
            if (kind_q == OP_BDM) begin
              pins.trst_o <= 1'b1;
              op_data_out <= {op_data_out[30:0], in_sync_q};
            end else begin
              pins.tck <= 1'b1;
              if (step_q >= pre && sidx < {1'b0, len_q}) begin
                op_data_out[sidx[4:0]] <= in_sync_q;
              end
            end
            step_q <= step_q + 7'd1;
          end else if (ph_q == {half[3:0], 1'b0} - 5'd1) begin
            ph_q     <= '0;
            pins.tck <= 1'b0;
            if (kind_q == OP_BDM) begin
              pins.trst_o <= 1'b0;
            end
            if (step_q == total_q) begin
              state_q     <= H_IDLE;
              op_busy_out <= 1'b0;
              op_done_out <= 1'b1;
              pins.trst_o <= 1'b1;
            end
          end
        end
        default: state_q <= H_IDLE;
      endcase
    end
  end

  // ****************************************
  // Static pin drives
  // ****************************************
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pins.test_mode     <= MODE_SCAN;
      pins.reset_input_n <= 1'b0;
      pins.trst_oe_n     <= 1'b1;
      pins.tms_oe_n      <= 1'b1;
      pins.tdi_oe_n      <= 1'b1;
    end else begin
      pins.reset_input_n <= cpu_reset_n_in;
      if (!cpu_reset_n_in) begin
        pins.test_mode <= mode_in; // [RULE8] [RULE23]
      end
      pins.trst_oe_n <= 1'b0;
      pins.tms_oe_n  <= 1'b0;
      pins.tdi_oe_n  <= 1'b0;
    end
  end

endmodule : dsp_host

/* File: dsp_chk.sv */
// Pin checks on the link between the debug port ends.
// Assumes plain dsp_if signals and the core clock domain.
module dsp_chk
  import dsp_pkg::*;
(
  input wire logic       core_clk_in,
  input wire logic       rst_n_in,
  input wire logic [3:0] test_mode,
  input wire logic       reset_input_n,
  input wire logic       tck,
  input wire logic       tdo_dso_o,
  input wire logic       tdo_dso_oe_n,
  input wire logic       status_clock_output,
  input wire logic       bus_clock_output,
  input wire logic [3:0] processor_status_nibble,
  input wire logic       data_bus_oe_n
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  a_dso_drive: assert property ((test_mode == MODE_BDM)[*6] |-> !tdo_dso_oe_n)
    else $error("dso not driven");
  a_tdo_fall: assert property (!tdo_dso_oe_n && !$past(tdo_dso_oe_n) && $changed(tdo_dso_o)
    && test_mode == MODE_SCAN |-> !tck) else $error("tdo moved with tck high");
  a_pst_clk: assert property ($past(rst_n_in) |-> status_clock_output != $past(status_clock_output))
    else $error("status clock stuck");
  a_bus_clk: assert property ($rose(bus_clock_output) |-> bus_clock_output[*2]
    ##1 !bus_clock_output[*2] ##1 bus_clock_output) else $error("bus clock period");
  a_pst_sync: assert property ($changed(processor_status_nibble) |-> $past(status_clock_output))
    else $error("status off clock");
  a_reset_float: assert property (!reset_input_n[*4] |-> data_bus_oe_n)
    else $error("data bus driven in reset");
  a_long_hold: assert property ($changed(processor_status_nibble) && processor_status_nibble >= PS_EXC
    |=> $stable(processor_status_nibble)[*3]) else $error("long code short");
  a_no_rsv: assert property (processor_status_nibble != PS_RSV2 && processor_status_nibble != PS_RSV6)
    else $error("reserved code shown");
endmodule : dsp_chk

/* File: testbench.sv */
// Joins device and debugger ends and runs scan, serial and status tests.
// Assumes the dsp_pkg constants and a 100 MHz core clock.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import dsp_pkg::*;
  logic clk = 0, rst_n = 0, c_rn = 0, go = 0, req = 0, drv = 1, done, ack, bkp, exc;
  logic [3:0] mode = 4'h0, cst = 4'h0;
  logic [1:0] kind = 2'h0, nb = 2'h0;
  logic [5:0] len = 6'h0;
  logic [31:0] din = 32'h0, dout, xd = 32'h87654321;
  int miscompares = 0, n_compared = 0, nbk = 0, i;
  dsp_if pins ();
  wire [3:0] psn = pins.processor_status_nibble;
  dsp_device u_dsp_device (.core_clk_in(clk), .rst_n_in(rst_n), .pins(pins), .core_status_in(cst),
    .core_xfer_req_in(req), .core_xfer_bytes_in(nb), .core_xfer_data_in(xd), .core_bus_data_in(16'hA55A),
    .core_bus_drive_in(drv), .core_xfer_ack_out(ack), .core_xfer_busy_out(), .core_breakpoint_out(bkp),
    .core_reset_exc_out(exc));
  dsp_host u_dsp_host (.core_clk_in(clk), .rst_n_in(rst_n), .pins(pins), .mode_in(mode), .cpu_reset_n_in(c_rn),
    .op_start_in(go), .op_kind_in(kind), .op_len_in(len), .op_data_in(din), .op_busy_out(),
    .op_done_out(done), .op_data_out(dout));
  dsp_chk u_dsp_chk (.core_clk_in(clk), .rst_n_in(rst_n), .test_mode(pins.test_mode),
    .reset_input_n(pins.reset_input_n), .tck(pins.tck), .tdo_dso_o(pins.tdo_dso_o),
    .tdo_dso_oe_n(pins.tdo_dso_oe_n), .status_clock_output(pins.status_clock_output),
    .bus_clock_output(pins.bus_clock_output), .processor_status_nibble(psn),
    .data_bus_oe_n(pins.data_bus_oe_n));
  initial begin
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (bkp === 1'b1) nbk++;
    if (ack === 1'b1) req <= 1'b0;
  end
  task automatic report_and_stop(input bit hung);
    if (hung) miscompares++;
    $display("compared %0d, mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : report_and_stop
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic op(input logic [1:0] k, input logic [5:0] n, input logic [31:0] d);
    @(posedge clk);
    kind <= k;
    len <= n;
    din <= d;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    for (i = 0; i < 2000 && done !== 1'b1; i++) @(negedge clk);
    if (i == 2000) report_and_stop(1);
  endtask : op
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (10) @(negedge clk);
    chk("bus_float", 32'h1, pins.data_bus_oe_n);
    chk("reset_exc", 32'h1, exc);
    op(OP_TAP_RESET, 6'h0, 32'h0);
    op(OP_DR, 6'h2, 32'h1);
    chk("bypass", 32'h2, dout[1:0]);
    op(OP_IR, 6'h4, {28'h0, IR_IDCODE});
    chk("ir_capture", IR_CAPTURE, dout[3:0]);
    op(OP_DR, 6'h20, 32'h0);
    chk("idcode", ID_VALUE, dout);
    repeat (300) @(negedge clk);
    op(OP_DR, 6'h20, 32'h0);
    chk("idcode_kept", ID_VALUE, dout);
    $display("test scan done");
    @(posedge clk);
    mode <= MODE_BDM;
    repeat (6) @(negedge clk);
    op(OP_BDM, 6'h8, {24'h0, CMD_BREAK});
    op(OP_TAP_RESET, 6'h0, 32'h0);
    op(OP_BDM, 6'h8, 32'h33);
    chk("ack", BDM_ACK, dout[7:0]);
    chk("breaks", 32'h2, nbk);
    op(OP_BDM, 6'h8, {24'h0, CMD_STATUS});
    chk("nak", BDM_NAK, dout[7:0]);
    op(OP_BDM, 6'h8, 32'h0);
    chk("status_rsp", {PS_EXC, 4'h0}, dout[7:0]);
    $display("test serial done");
    @(posedge clk);
    c_rn <= 1'b1;
    cst <= PS_HALT;
    repeat (12) @(negedge clk);
    chk("halt", PS_HALT, psn);
    chk("bus_drive", 32'h0, pins.data_bus_oe_n);
    @(posedge clk);
    cst <= PS_RSV2;
    repeat (8) @(negedge clk);
    chk("reserved", PS_CONT, psn);
    for (int b = 0; b < 4; b++) begin
      @(posedge clk);
      nb <= b[1:0];
      req <= 1'b1;
      for (i = 0; i < 60 && psn !== PS_XFER1 + b; i++) @(negedge clk);
      if (i == 60) report_and_stop(1);
      chk("xfer_code", PS_XFER1 + b, psn);
      for (int k = 0; k < 2 * b + 2; k++) begin
        repeat (2) @(negedge clk);
        chk("nibble", xd[4*k+:4], pins.debug_data_nibble);
      end
    end
    $display("test status done");
    report_and_stop(0);
  end
endmodule : testbench
